// ===== dv/spt_bus_master.sv
// Behavioural two-wire bus master for the serial port bench.
// Assumes open-drain lines whose pull-ups the bench resolves.
`timescale 1ns/10ps
`default_nettype none
module spt_bus_master (
    // Resolved bus lines
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Pull-low enables
    output var logic  scl_oe_o,
    output var logic  sda_oe_o
);
    localparam real HALF = 62.5;
    logic stalled = 1'b0;
    // ----------
    // Line tasks
    // ----------
    // Lines released at time zero, clock still between frames
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // Release clock, wait bounded for a stretch to end, then hold high
    task automatic rise();
        int n;
        n = 0;
        scl_oe_o = 1'b0;
        while (scl_i !== 1'b1 && n < 5000) begin
            #8;
            n++;
        end
        if (n == 5000) stalled = 1'b1;
        #(HALF);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_oe_o = 1'b0;
        #(HALF / 2);
        rise();
        sda_oe_o = 1'b1;
        #(HALF);
        scl_oe_o = 1'b1;
        #(HALF / 2);
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        sda_oe_o = 1'b1;
        #(HALF / 2);
        rise();
        sda_oe_o = 1'b0;
        #(HALF);
    endtask
    // Byte MSB first, then data released for the acknowledge slot
    task automatic xfer(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_oe_o = ~d[i];
            #(HALF / 2);
            rise();
            scl_oe_o = 1'b1;
            #(HALF / 2);
        end
        sda_oe_o = 1'b0;
        #(HALF / 2);
        rise();
        ack = ~sda_i;
        scl_oe_o = 1'b1;
        #(HALF / 2);
    endtask
endmodule // spt_bus_master
`default_nettype wire

// ===== dv/spt_port_tb.sv
// Self-checking bench of the serial slave port.
// Assumes the bus master model and the register offsets header.
`timescale 1ns/10ps
`default_nettype none
`include "spt_defs.svh"
module spt_port_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic        pins_in = 1'b1;
    logic        alt = 1'b0;
    logic        lack = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o, psc_o, psc_oe, psd_o, psd_oe, asc_o, asc_oe, asd_o, asd_oe;
    logic        m_scl_oe, m_sda_oe;
    logic [63:0] exp_q [$];
    int          fails = 0;
    int          tests_run = 0;
    int          seed = 32'h85667d3d;
    logic [7:0]  d1, d2;
    logic [3:0]  modes [6] = '{`SPT_MODE_S7, `SPT_MODE_S10, `SPT_MODE_S7SS,
                               `SPT_MODE_S10SS, `SPT_MODE_FWM, 4'h0};
    logic [7:0]  regs [7] = '{`SPT_ADR_CTRL, `SPT_ADR_STAT, `SPT_ADR_BUF,
                              `SPT_ADR_ADDR, `SPT_ADR_MISC, `SPT_ADR_FLAGS, 8'h00};
    event        pin_ev;
    // Wired-AND lines with pull-ups, master on the selected pair
    wire logic pscl = ~(psc_oe | (~alt & m_scl_oe));
    wire logic psda = ~(psd_oe | (~alt & m_sda_oe));
    wire logic ascl = ~(asc_oe | (alt & m_scl_oe));
    wire logic asda = ~(asd_oe | (alt & m_sda_oe));
    wire logic [31:0] pvec = {28'h0, m.stalled, |{psc_o, psd_o, asc_o, asd_o},
                              alt ? asc_oe : psc_oe, lack};
    // Clock
    always #4 clk_i = ~clk_i;
    spt_port spt_port_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .pins_input_i(pins_in), .pri_scl_i(pscl), .pri_scl_o(psc_o),
        .pri_scl_oe_o(psc_oe), .pri_sda_i(psda), .pri_sda_o(psd_o), .pri_sda_oe_o(psd_oe),
        .alt_scl_i(ascl), .alt_scl_o(asc_o), .alt_scl_oe_o(asc_oe), .alt_sda_i(asda),
        .alt_sda_o(asd_o), .alt_sda_oe_o(asd_oe));
    spt_bus_master m (.scl_i(alt ? ascl : pscl), .sda_i(alt ? asda : psda),
        .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
    // ----------
    // Tasks
    // ----------
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Oldest note against an observed value under a mask
    task automatic cmp(input logic [31:0] got);
        logic [63:0] e;
        e = 64'h0;
        tests_run++;
        if (exp_q.size() == 0) begin
            fails++;
            $display("ERROR %0t: result with no note", $time);
        end else begin
            e = exp_q.pop_front();
            if ((got & e[63:32]) !== e[31:0]) begin
                fails++;
                $display("ERROR %0t: got %h want %h", $time, got & e[63:32], e[31:0]);
            end
        end
    endtask
    // Classic single Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) begin
            fails++;
            $display("ERROR %0t: no bus acknowledge", $time);
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] mk = 32'hFFFFFFFF);
        exp_q.push_back({mk, e});
        wb(1'b0, a, 32'h0);
    endtask
    // Pin state note; stall and driven-high bits must stay clear
    task automatic pin(input logic [31:0] e, input logic [31:0] mk);
        repeat (4) @(posedge clk_i);
        exp_q.push_back({mk | 32'hC, e});
        ->pin_ev;
    endtask
    task automatic snd(input logic [7:0] d, input logic a);
        m.xfer(d, lack);
        repeat (8) @(posedge clk_i);
        pin({31'h0, a}, 32'h1);
    endtask
    // Watchers: read data at ack, pin state on request
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && cyc && !we) cmp(dat_o);
    end
    always @(pin_ev) cmp(pvec);
    // Overall limit
    initial begin
        #700000;
        fails++;
        $display("ERROR %0t: overall limit reached", $time);
        test_done();
    end
    // ----------
    // Sequence
    // ----------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(8'h00, 32'hFF);
        wr(`SPT_ADR_STAT, 32'hFF);
        foreach (regs[i]) rd(regs[i], 32'h0);
        wr(`SPT_ADR_ADDR, 32'hA4);
        wr(`SPT_ADR_CTRL, 32'h06);
        m.start();
        snd(8'hA4, 1'b0);
        rd(`SPT_ADR_FLAGS, 32'h0);
        m.stop();
        wr(`SPT_ADR_CTRL, 32'h26);
        m.start();
        snd(8'hA4, 1'b1);
        rd(`SPT_ADR_STAT, 32'h01, 32'h27);
        rd(`SPT_ADR_FLAGS, 32'h08);
        rd(`SPT_ADR_BUF, 32'hA4);
        rd(`SPT_ADR_STAT, 32'h00, 32'h01);
        wr(`SPT_ADR_FLAGS, 32'h0);
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        snd(d1, 1'b1);
        rd(`SPT_ADR_STAT, 32'h21, 32'h21);
        snd(d2, 1'b0);
        rd(`SPT_ADR_FLAGS, 32'h08);
        rd(`SPT_ADR_CTRL, 32'h66);
        rd(`SPT_ADR_BUF, {24'h0, d1});
        snd(d2, 1'b0);
        rd(`SPT_ADR_CTRL, 32'h66);
        wr(`SPT_ADR_CTRL, 32'h26);
        snd(d2, 1'b1);
        rd(`SPT_ADR_BUF, {24'h0, d2});
        wr(`SPT_ADR_MISC, 32'h80);
        pin(32'h2, 32'h2);
        wr(`SPT_ADR_MISC, 32'h0);
        pin(32'h0, 32'h2);
        m.stop();
        wr(`SPT_ADR_CTRL, 32'h2E);
        wr(`SPT_ADR_FLAGS, 32'h0);
        m.start();
        rd(`SPT_ADR_FLAGS, 32'h08);
        rd(`SPT_ADR_STAT, 32'h08, 32'h08);
        wr(`SPT_ADR_FLAGS, 32'h0);
        snd(8'h30, 1'b0);
        rd(`SPT_ADR_FLAGS, 32'h0);
        m.stop();
        rd(`SPT_ADR_FLAGS, 32'h08);
        rd(`SPT_ADR_STAT, 32'h10, 32'h10);
        foreach (modes[i]) begin
            wr(`SPT_ADR_CTRL, {28'h2, modes[i]});
            rd(`SPT_ADR_CTRL, {28'h2, modes[i]});
            m.start();
            snd(8'hA4, modes[i] == `SPT_MODE_S7 || modes[i] == `SPT_MODE_S7SS);
            m.stop();
            rd(`SPT_ADR_BUF, 32'hA4);
        end
        wr(`SPT_ADR_CTRL, 32'h27);
        wr(`SPT_ADR_ADDR, 32'hF2);
        m.start();
        snd(8'hF2, 1'b1);
        rd(`SPT_ADR_STAT, 32'h03, 32'h03);
        pin(32'h2, 32'h2);
        wr(`SPT_ADR_ADDR, 32'h5A);
        rd(`SPT_ADR_BUF, 32'hF2);
        pin(32'h0, 32'h2);
        snd(8'h5A, 1'b1);
        rd(`SPT_ADR_STAT, 32'h03, 32'h03);
        wr(`SPT_ADR_ADDR, 32'hF2);
        rd(`SPT_ADR_BUF, 32'h5A);
        pin(32'h0, 32'h2);
        m.start();
        snd(8'hF3, 1'b1);
        rd(`SPT_ADR_STAT, 32'h05, 32'h07);
        wr(`SPT_ADR_ADDR, 32'hF2);
        rd(`SPT_ADR_BUF, 32'hF3);
        m.stop();
        wr(`SPT_ADR_CTRL, 32'h26);
        wr(`SPT_ADR_ADDR, 32'hA4);
        wr(`SPT_ADR_MISC, 32'h10);
        alt <= 1'b1;
        m.start();
        snd(8'hA4, 1'b1);
        m.stop();
        rd(`SPT_ADR_BUF, 32'hA4);
        alt <= 1'b0;
        m.start();
        snd(8'hA4, 1'b0);
        m.stop();
        wr(`SPT_ADR_MISC, 32'h0);
        pins_in <= 1'b0;
        m.start();
        snd(8'hA4, 1'b0);
        m.stop();
        test_done();
    end
endmodule // spt_port_tb
`default_nettype wire

// ===== rtl/spt_defs.svh
// Offsets, field positions, reset values and mode codes of the serial port.
// Assumes byte addresses on a 32-bit classic Wishbone bus.
`ifndef SPT_DEFS_SVH
`define SPT_DEFS_SVH
`define SPT_ADR_CTRL  8'h14
`define SPT_ADR_STAT  8'h18
`define SPT_ADR_BUF   8'h1C
`define SPT_ADR_ADDR  8'h20
`define SPT_ADR_MISC  8'h24
`define SPT_ADR_FLAGS 8'h28
`define SPT_CTRL_OV   6
`define SPT_CTRL_EN   5
`define SPT_MISC_HOLD 7
`define SPT_MISC_SEL  4
`define SPT_FLAG_IF   3
`define SPT_RST_BYTE  8'h00
`define SPT_MODE_S7    4'h6
`define SPT_MODE_S10   4'h7
`define SPT_MODE_S7SS  4'hE
`define SPT_MODE_S10SS 4'hF
`define SPT_MODE_FWM   4'hB
`define SPT_BITS_ADDR  4'h8
`define SPT_BITS_ACK   4'h9
`define SPT_TEN_HDR    5'h1E
`endif

// ===== rtl/spt_pkg.sv
// Types shared by the serial port design.
// Assumes nothing of its surroundings.
package spt_pkg;
    typedef enum logic [1:0] {SPT_IDLE, SPT_RECV, SPT_SKIP} spt_state_t;
endpackage

// ===== rtl/spt_port.sv
// Two-wire serial slave port with Wishbone register access.
// Assumes external pull-ups on the bus lines and pins resolved from the enables.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "spt_defs.svh"
module spt_port (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Pin direction: high while software sets the port pins as inputs
    input  wire logic        pins_input_i,
    // Primary pair
    input  wire logic        pri_scl_i,
    output logic             pri_scl_o,
    output logic             pri_scl_oe_o,
    input  wire logic        pri_sda_i,
    output logic             pri_sda_o,
    output logic             pri_sda_oe_o,
    // Alternate pair
    input  wire logic        alt_scl_i,
    output logic             alt_scl_o,
    output logic             alt_scl_oe_o,
    input  wire logic        alt_sda_i,
    output logic             alt_sda_o,
    output logic             alt_sda_oe_o
);
    import spt_pkg::*;

    //--------------------------------------------------------------
    // Registers and state
    //--------------------------------------------------------------
    logic [7:0] ctrl, addr_reg, misc, buf_reg, sr;
    logic       ov, bf, ua, pif, st_s, st_p, st_da, st_rw;
    logic       clr_pend, ua_hold, sda_drv, pend_if, pend_ua;
    logic       is_data, ten_lo, ten_ok;
    logic [3:0] cnt;
    logic [3:0] sync1, sync2;
    logic       scl_q, sda_q, line_lo;
    spt_state_t state;

    //--------------------------------------------------------------
    // Line synchronisers and condition detection
    //--------------------------------------------------------------
    // Two stages on every pin before any logic looks at it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
        end else begin
            sync1 <= {pri_scl_i, pri_sda_i, alt_scl_i, alt_sda_i};
            sync2 <= sync1;
        end
    end

    logic en, sel, scl_s, sda_s, scl_r, scl_f, start, stop;
    assign en    = ctrl[`SPT_CTRL_EN];
    assign sel   = misc[`SPT_MISC_SEL];
    assign scl_s = sel ? sync2[1] : sync2[3];
    assign sda_s = sel ? sync2[0] : sync2[2];

    // Previous samples for edge finding
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_r = en & scl_s & ~scl_q;
    assign scl_f = en & ~scl_s & scl_q;
    assign start = en & scl_s & scl_q & sda_q & ~sda_s;
    assign stop  = en & scl_s & scl_q & ~sda_q & sda_s;

    //--------------------------------------------------------------
    // Mode decode and byte decisions
    //--------------------------------------------------------------
    logic [3:0] mode;
    logic slv, ten, ss_int, busy, fall8, fall9, ack_slot;
    logic hit7, hi_ok, accept, upd, clean;
    assign mode = ctrl[3:0];
    always_comb begin
        slv    = 1'b1;
        ten    = 1'b0;
        ss_int = 1'b0;
        case (mode)
            `SPT_MODE_S7:    ;
            `SPT_MODE_S10:   ten = 1'b1;
            `SPT_MODE_S7SS:  ss_int = 1'b1;
            `SPT_MODE_S10SS: begin
                ten    = 1'b1;
                ss_int = 1'b1;
            end
            `SPT_MODE_FWM: begin
                slv    = 1'b0;
                ss_int = 1'b1;
            end
            default: slv = 1'b0;
        endcase
    end

    assign busy     = (state == SPT_RECV);
    assign fall8    = busy & scl_f & (cnt == `SPT_BITS_ADDR);
    assign fall9    = busy & scl_f & (cnt == `SPT_BITS_ACK);
    assign ack_slot = busy & (cnt == `SPT_BITS_ADDR);
    assign hit7     = (sr[7:1] == addr_reg[7:1]);
    assign hi_ok    = hit7 & (sr[7:3] == `SPT_TEN_HDR);

    // Whether the byte just shifted in belongs to this slave
    always_comb begin
        accept = 1'b0;
        upd    = 1'b0;
        if (is_data) begin
            accept = 1'b1;
        end else if (!ten) begin
            accept = hit7;
        end else if (ten_lo) begin
            accept = (sr == addr_reg);
            upd    = accept;
        end else begin
            accept = hi_ok;
            upd    = hi_ok & ~ten_ok;
        end
    end
    assign clean = accept & ~bf & ~ov;

    //--------------------------------------------------------------
    // Receive sequencer
    //--------------------------------------------------------------
    // Waits for start, counts bits, acknowledges and tracks address phase
    always_ff @(posedge clk_i) begin
        if (rst_i || !en || !slv) begin
            state   <= SPT_IDLE;
            cnt     <= 4'h0;
            sr      <= `SPT_RST_BYTE;
            sda_drv <= 1'b0;
            pend_if <= 1'b0;
            pend_ua <= 1'b0;
            is_data <= 1'b0;
            ten_lo  <= 1'b0;
            ten_ok  <= 1'b0;
        end else if (stop) begin
            state   <= SPT_IDLE;
            sda_drv <= 1'b0;
            ten_ok  <= 1'b0;
        end else if (start) begin
            state   <= SPT_RECV;
            cnt     <= 4'h0;
            sda_drv <= 1'b0;
            pend_if <= 1'b0;
            pend_ua <= 1'b0;
            is_data <= 1'b0;
            ten_lo  <= 1'b0;
        end else if (busy) begin
            if (scl_r) begin
                sr  <= {sr[6:0], sda_s};
                cnt <= cnt + 4'h1;
            end
            if (fall8) begin
                sda_drv <= clean;
                pend_if <= accept;
                pend_ua <= upd & clean;
                if (!accept) begin
                    state <= SPT_SKIP;
                end else if (!is_data) begin
                    if (ten && !ten_ok && !ten_lo) begin
                        ten_lo <= 1'b1;
                    end else begin
                        ten_lo  <= 1'b0;
                        ten_ok  <= ten;
                        is_data <= 1'b1;
                    end
                end
            end
            if (fall9) begin
                sda_drv <= 1'b0;
                pend_if <= 1'b0;
                pend_ua <= 1'b0;
                cnt     <= 4'h0;
            end
        end
    end

    //--------------------------------------------------------------
    // Wishbone slave
    //--------------------------------------------------------------
    logic req, wr, rd_buf;
    logic [7:0] rd_byte;
    assign req    = cyc_i & stb_i & ~ack_o;
    assign wr     = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    assign rd_buf = cyc_i & stb_i & ~we_i & ack_o & (adr_i == `SPT_ADR_BUF);

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        case (adr_i)
            `SPT_ADR_CTRL:  rd_byte = {ctrl[7], ov, ctrl[5:0]};
            `SPT_ADR_STAT:  rd_byte = {2'b00, st_da, st_p, st_s, st_rw, ua, bf};
            `SPT_ADR_BUF:   rd_byte = buf_reg;
            `SPT_ADR_ADDR:  rd_byte = addr_reg;
            `SPT_ADR_MISC:  rd_byte = misc;
            `SPT_ADR_FLAGS: rd_byte = {4'h0, pif, 3'b000};
            default:        rd_byte = `SPT_RST_BYTE;
        endcase
    end

    // One wait state, then a single-cycle acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            if (req) begin
                dat_o <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Software-owned registers; the overflow bit is written in its own block below
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= `SPT_RST_BYTE;
            addr_reg <= `SPT_RST_BYTE;
            misc     <= `SPT_RST_BYTE;
        end else if (wr) begin
            case (adr_i)
                `SPT_ADR_CTRL: ctrl <= dat_i[7:0];
                `SPT_ADR_ADDR: addr_reg <= dat_i[7:0];
                `SPT_ADR_MISC: misc <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Status flags
    //--------------------------------------------------------------
    logic wr_ctrl, wr_addr, wr_flags;
    assign wr_ctrl  = wr & (adr_i == `SPT_ADR_CTRL);
    assign wr_addr  = wr & (adr_i == `SPT_ADR_ADDR);
    assign wr_flags = wr & (adr_i == `SPT_ADR_FLAGS);

    // Overflow: set wins over a software write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ov <= 1'b0;
        end else if (fall8 && accept && bf) begin
            ov <= 1'b1;
        end else if (wr_ctrl) begin
            ov <= dat_i[`SPT_CTRL_OV];
        end
    end

    // Buffer and buffer-full with deferred clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_reg  <= `SPT_RST_BYTE;
            bf       <= 1'b0;
            clr_pend <= 1'b0;
            st_da    <= 1'b0;
            st_rw    <= 1'b0;
        end else if (fall8 && clean) begin
            buf_reg  <= sr;
            bf       <= 1'b1;
            clr_pend <= 1'b0;
            st_da    <= is_data;
            if (!is_data) begin
                st_rw <= sr[0];
            end
        end else if (rd_buf) begin
            clr_pend <= 1'b1;
        end else if (clr_pend && !ack_slot) begin
            bf       <= 1'b0;
            clr_pend <= 1'b0;
        end
    end

    // Address update flag and clock hold; address write releases
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            ua      <= 1'b0;
            ua_hold <= 1'b0;
        end else if (fall9 && pend_ua) begin
            ua      <= 1'b1;
            ua_hold <= 1'b1;
        end else if (wr_addr) begin
            ua      <= 1'b0;
            ua_hold <= 1'b0;
        end
    end

    // Start and stop status, cleared while disabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            st_s <= 1'b0;
            st_p <= 1'b0;
        end else if (start) begin
            st_s <= 1'b1;
            st_p <= 1'b0;
        end else if (stop) begin
            st_s <= 1'b0;
            st_p <= 1'b1;
        end
    end

    // Port interrupt flag: hardware set wins over software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pif <= 1'b0;
        end else if ((fall9 && pend_if) || (ss_int && (start || stop))) begin
            pif <= 1'b1;
        end else if (wr_flags) begin
            pif <= dat_i[`SPT_FLAG_IF];
        end
    end

    //--------------------------------------------------------------
    // Pin drivers
    //--------------------------------------------------------------
    logic drv_ok, scl_drv;
    assign drv_ok  = en & pins_input_i;
    assign scl_drv = ua_hold | misc[`SPT_MISC_HOLD];

    // Lines only ever pulled low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_lo      <= 1'b0;
            pri_scl_oe_o <= 1'b0;
            pri_sda_oe_o <= 1'b0;
            alt_scl_oe_o <= 1'b0;
            alt_sda_oe_o <= 1'b0;
        end else begin
            line_lo      <= 1'b0;
            pri_scl_oe_o <= drv_ok & ~sel & scl_drv;
            pri_sda_oe_o <= drv_ok & ~sel & sda_drv;
            alt_scl_oe_o <= drv_ok & sel & scl_drv;
            alt_sda_oe_o <= drv_ok & sel & sda_drv;
        end
    end
    assign pri_scl_o = line_lo;
    assign pri_sda_o = line_lo;
    assign alt_scl_o = line_lo;
    assign alt_sda_o = line_lo;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    enable_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !en |=> !pri_sda_oe_o && !alt_sda_oe_o && !pri_scl_oe_o && !alt_scl_oe_o)
        else $error("pin driven while port disabled");
    pin_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(pri_sda_oe_o && alt_sda_oe_o) && !(pri_scl_oe_o && alt_scl_oe_o))
        else $error("both pin pairs driven");
    buffer_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fall8 && clean |=> bf && buf_reg == $past(sr))
        else $error("clean byte not buffered");
    overflow_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fall8 && accept && bf |=> ov)
        else $error("overflow not flagged");
    no_ack_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fall8 && (bf || ov) |=> !sda_drv && $stable(buf_reg))
        else $error("acked or loaded while full");
    ninth_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fall9 && pend_if |=> pif)
        else $error("flag not set at ninth fall");
    ack_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fall9 |=> !sda_drv ##2 !pri_sda_oe_o && !alt_sda_oe_o)
        else $error("acknowledge not released");
    bf_defer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bf && ack_slot && !(fall8 && clean) |=> bf)
        else $error("buffer full cleared inside acknowledge");
    ua_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_addr && !(fall9 && pend_ua) |=> !ua && !ua_hold)
        else $error("address write did not release");
    start_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && !stop |=> st_s && !st_p)
        else $error("start not recorded");
    master_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == `SPT_MODE_FWM |=> state == SPT_IDLE)
        else $error("slave active in master mode");
endmodule // spt_port
`default_nettype wire
